// ===== psf_pkg.sv
// Shared constants, types and helpers of the processor status flags block
`default_nettype none
package psf_pkg;

  // Special function register placement
  localparam logic [7:0] STATUS_ADDR     = 8'hd0;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] STATUS_BIT_BASE = 8'hd0;
  localparam logic [7:0] RD_IDLE         = 8'h00;

  // Bit positions inside the status word
  localparam int unsigned CARRY_POS    = 7;
  localparam int unsigned HALF_POS     = 6;
  localparam int unsigned USER_A_POS   = 5;
  localparam int unsigned BANK_HI_POS  = 4;
  localparam int unsigned BANK_LO_POS  = 3;
  localparam int unsigned EXCEEDS_POS  = 2;
  localparam int unsigned USER_B_POS   = 1;
  localparam int unsigned PARITY_POS   = 0;

  // Working register banks
  localparam int unsigned BANK_W       = 2;
  localparam int unsigned REG_IDX_W    = 3;
  localparam int unsigned RAM_ADDR_W   = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned NIBBLE_W     = 4;

  typedef enum logic [2:0] {
    PSF_OP_ADD,
    PSF_OP_SUB,
    PSF_OP_MUL,
    PSF_OP_DIV
  } psf_op_t;

  // Status word, most significant field first
  typedef struct packed {
    logic carryFlag;
    logic halfCarryFlag;
    logic userFlagA;
    logic bankSelectHigh;
    logic bankSelectLow;
    logic arithExceedsFlag;
    logic userFlagB;
    logic parityFlag;
  } psf_status_t;

  // One arithmetic operation reported by the core datapath
  typedef struct packed {
    logic              valid;
    psf_op_t           op;
    logic [DATA_W-1:0] opA;
    logic [DATA_W-1:0] opB;
    logic              carryIn;
  } psf_arith_req_t;

  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic exceeds;
  } psf_arith_res_t;

  function automatic logic oddParity(input logic [DATA_W-1:0] v);
    return ^v;
  endfunction

  function automatic logic [RAM_ADDR_W-1:0] regRamAddr(input logic [BANK_W-1:0] bank,
                                                       input logic [REG_IDX_W-1:0] idx);
    return {{(RAM_ADDR_W-BANK_W-REG_IDX_W){1'b0}}, bank, idx};
  endfunction

endpackage
`default_nettype wire

// ===== psf_flag_calc.sv
// Combinational condition flag evaluation for one arithmetic operation
`timescale 1ns/1ps
`default_nettype none
module psf_flag_calc #(
  parameter int unsigned W = psf_pkg::DATA_W
) (
  input  wire psf_pkg::psf_arith_req_t req,
  output var  psf_pkg::psf_arith_res_t res
);

  localparam int unsigned NW = psf_pkg::NIBBLE_W;

  wire logic [W:0]      addWide  = {1'b0, req.opA} + {1'b0, req.opB} + {{W{1'b0}}, req.carryIn};
  wire logic [W:0]      subWide  = {1'b0, req.opA} - {1'b0, req.opB} - {{W{1'b0}}, req.carryIn};
  wire logic [NW:0]     addNib   = {1'b0, req.opA[NW-1:0]} + {1'b0, req.opB[NW-1:0]}
                                   + {{NW{1'b0}}, req.carryIn};
  wire logic [NW:0]     subNib   = {1'b0, req.opA[NW-1:0]} - {1'b0, req.opB[NW-1:0]}
                                   - {{NW{1'b0}}, req.carryIn};
  wire logic [2*W-1:0]  product  = {{W{1'b0}}, req.opA} * {{W{1'b0}}, req.opB};
  wire logic            mulOver  = |product[2*W-1:W];
  wire logic            divZero  = ~|req.opB;

  // Multiply and divide give no carry or nibble carry, so both are cleared
  always_comb begin
    res = '0;
    case (req.op)
      psf_pkg::PSF_OP_ADD: begin
        res.carry     = addWide[W];
        res.halfCarry = addNib[NW];
        res.exceeds   = addWide[W];
      end
      psf_pkg::PSF_OP_SUB: begin
        res.carry     = subWide[W];
        res.halfCarry = subNib[NW];
        res.exceeds   = subWide[W];
      end
      psf_pkg::PSF_OP_MUL: begin
        res.exceeds   = mulOver;
      end
      psf_pkg::PSF_OP_DIV: begin
        res.exceeds   = divZero;
      end
      default: begin
        res = '0;
      end
    endcase
  end

endmodule // psf_flag_calc
`default_nettype wire

// ===== psf_status_word.sv
// Processor status word: condition flags, user flags and register bank select
`timescale 1ns/1ps
`default_nettype none
module psf_status_word #(
  parameter int unsigned DW = psf_pkg::DATA_W
) (
  input  wire  logic                                  clk,
  input  wire  logic                                  arst_n,
  // Byte access in the special function register space
  input  wire  logic [7:0]                            sfrAddr,
  input  wire  logic                                  sfrWrEn,
  input  wire  logic [7:0]                            sfrWrData,
  input  wire  logic                                  sfrRdEn,
  output logic [7:0]                                  sfrRdData_q,
  output logic                                        sfrRdHit_q,
  // Single bit access in the bit-addressable space
  input  wire  logic                                  bitWrEn,
  input  wire  logic [7:0]                            bitAddr,
  input  wire  logic                                  bitWrData,
  // Core datapath
  input  wire  psf_pkg::psf_arith_req_t               arithReq,
  input  wire  logic [DW-1:0]                         accValue,
  input  wire  logic                                  regAccess,
  input  wire  logic [psf_pkg::REG_IDX_W-1:0]         regIndex,
  output logic [psf_pkg::RAM_ADDR_W-1:0]              regRamAddr_q,
  output logic                                        regRamValid_q,
  output psf_pkg::psf_status_t                        statusWord_q
);

  psf_pkg::psf_arith_res_t arithRes;
  psf_pkg::psf_status_t    statusD;

  // Bit addresses carry the bit number in their low bits
  localparam int unsigned SEL_W = $clog2(psf_pkg::DATA_W);
  localparam int unsigned TOP_B = psf_pkg::DATA_W - 1;

  psf_flag_calc #(
    .W   (DW)
  ) u_flag_calc (
    .req (arithReq),
    .res (arithRes)
  );

  // Address decode for byte and bit paths
  wire logic             byteWrHit = sfrWrEn && (sfrAddr == psf_pkg::STATUS_ADDR);
  wire logic             byteRdHit = sfrRdEn && (sfrAddr == psf_pkg::STATUS_ADDR);
  wire logic             bitWrHit  = bitWrEn && (bitAddr[TOP_B:SEL_W] == psf_pkg::STATUS_BIT_BASE[TOP_B:SEL_W]);
  wire logic [SEL_W-1:0] bitSel    = bitAddr[SEL_W-1:0];

  // Software view: a whole-byte store or a single bit store
  wire logic [7:0] statusVec = statusWord_q;
  wire logic [7:0] bitMask   = 8'h01 << bitSel;
  wire logic [7:0] bitMerged = bitWrData ? (statusVec | bitMask) : (statusVec & ~bitMask);
  wire logic [7:0] swVec     = byteWrHit ? sfrWrData : (bitWrHit ? bitMerged : statusVec);

  // Hardware flags win over a software store in the same cycle
  wire logic       hwArith   = arithReq.valid;
  wire logic [psf_pkg::BANK_W-1:0] bankNow = {statusWord_q.bankSelectHigh, statusWord_q.bankSelectLow};

  always_comb begin
    statusD                  = psf_pkg::psf_status_t'(swVec);
    statusD.userFlagA        = swVec[psf_pkg::USER_A_POS];
    statusD.userFlagB        = swVec[psf_pkg::USER_B_POS];
    statusD.bankSelectHigh   = swVec[psf_pkg::BANK_HI_POS];
    statusD.bankSelectLow    = swVec[psf_pkg::BANK_LO_POS];
    if (hwArith) begin
      statusD.carryFlag        = arithRes.carry;
      statusD.halfCarryFlag    = arithRes.halfCarry;
      statusD.arithExceedsFlag = arithRes.exceeds;
    end
    // Parity is not software writable; it follows the accumulator
    statusD.parityFlag       = psf_pkg::oddParity(accValue);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusWord_q <= psf_pkg::psf_status_t'(psf_pkg::STATUS_RESET);
    end else begin
      statusWord_q <= statusD;
    end
  end

  // Register read returns the word one cycle after the strobe
  wire logic [7:0] rdD = byteRdHit ? statusVec : psf_pkg::RD_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdData_q <= psf_pkg::RD_IDLE;
      sfrRdHit_q  <= 1'b0;
    end else begin
      sfrRdData_q <= rdD;
      sfrRdHit_q  <= byteRdHit;
    end
  end

  // Bank taken from the stored word, so a new bank affects the next access
  wire logic [psf_pkg::RAM_ADDR_W-1:0] regAddrD = psf_pkg::regRamAddr(bankNow, regIndex);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRamAddr_q  <= '0;
      regRamValid_q <= 1'b0;
    end else begin
      regRamValid_q <= regAccess;
      if (regAccess) begin
        regRamAddr_q <= regAddrD;
      end
    end
  end

  // Independent reference values for the checks below
  localparam int unsigned NW = psf_pkg::NIBBLE_W;
  wire logic [DW:0]   refAdd    = {1'b0, arithReq.opA} + {1'b0, arithReq.opB} + {{DW{1'b0}}, arithReq.carryIn};
  wire logic          refBorrow = ({1'b0, arithReq.opA} < ({1'b0, arithReq.opB} + {{DW{1'b0}}, arithReq.carryIn}));
  wire logic [NW:0]   refNib    = {1'b0, arithReq.opA[NW-1:0]} + {1'b0, arithReq.opB[NW-1:0]}
                                  + {{NW{1'b0}}, arithReq.carryIn};
  // Low nibble borrow: minuend nibble below subtrahend nibble plus borrow-in
  wire logic          refNibBorrow = ({1'b0, arithReq.opA[NW-1:0]} <
                                      ({1'b0, arithReq.opB[NW-1:0]} + {{NW{1'b0}}, arithReq.carryIn}));
  wire logic          refMulOver = ({{DW{1'b0}}, arithReq.opA} * {{DW{1'b0}}, arithReq.opB})
                                   > {{DW{1'b0}}, {DW{1'b1}}};
  wire logic          isAdd   = hwArith && (arithReq.op == psf_pkg::PSF_OP_ADD);
  wire logic          isSub   = hwArith && (arithReq.op == psf_pkg::PSF_OP_SUB);
  wire logic          isMul   = hwArith && (arithReq.op == psf_pkg::PSF_OP_MUL);
  wire logic          isDiv   = hwArith && (arithReq.op == psf_pkg::PSF_OP_DIV);

  a_carry_add: assert property (
    @(posedge clk) disable iff (!arst_n)
    isAdd |=> (statusWord_q.carryFlag == $past(refAdd[DW]))
              && (statusWord_q.arithExceedsFlag == statusWord_q.carryFlag))
    else $error("carry flag wrong after addition");

  a_carry_sub: assert property (
    @(posedge clk) disable iff (!arst_n)
    isSub |=> statusWord_q.carryFlag == $past(refBorrow))
    else $error("carry flag wrong after subtraction");

  a_half_carry: assert property (
    @(posedge clk) disable iff (!arst_n)
    (isAdd |=> statusWord_q.halfCarryFlag == $past(refNib[NW])) and
    ((isMul || isDiv) |=> !statusWord_q.halfCarryFlag && !statusWord_q.carryFlag))
    else $error("half-carry flag wrong after arithmetic");

  a_sub_half: assert property (
    @(posedge clk) disable iff (!arst_n)
    isSub |=> (statusWord_q.halfCarryFlag == $past(refNibBorrow))
              && (statusWord_q.arithExceedsFlag == statusWord_q.carryFlag))
    else $error("half-carry or overflow flag wrong after subtraction");

  a_exceeds_muldiv: assert property (
    @(posedge clk) disable iff (!arst_n)
    (isMul |=> statusWord_q.arithExceedsFlag == $past(refMulOver)) and
    (isDiv |=> statusWord_q.arithExceedsFlag == ($past(arithReq.opB) == '0)))
    else $error("overflow flag wrong after multiply or divide");

  // Sampled reset skips the release edge, where the word still shows zero
  a_parity_track: assert property (
    @(posedge clk) disable iff (!arst_n)
    arst_n |=> statusWord_q.parityFlag == (^$past(accValue)))
    else $error("parity flag does not follow accumulator");

  a_bank_address: assert property (
    @(posedge clk) disable iff (!arst_n)
    regAccess |=> regRamValid_q
                  && (regRamAddr_q == ($past(bankNow) * (2 ** psf_pkg::REG_IDX_W) + $past(regIndex))))
    else $error("register address not bank times eight plus index");

  a_user_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !(byteWrHit || bitWrHit) |=> $stable(statusWord_q.userFlagA) && $stable(statusWord_q.userFlagB)
                                 && $stable(bankNow))
    else $error("user flag or bank changed without software store");

  a_read_back: assert property (
    @(posedge clk) disable iff (!arst_n)
    byteRdHit |=> sfrRdHit_q && (sfrRdData_q == $past(statusVec)))
    else $error("status word read returned wrong value");

  a_flags_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!hwArith && !byteWrHit && !bitWrHit) |=> $stable(statusWord_q.carryFlag)
                                              && $stable(statusWord_q.halfCarryFlag)
                                              && $stable(statusWord_q.arithExceedsFlag))
    else $error("condition flag changed without a cause");

  a_bit_store: assert property (
    @(posedge clk) disable iff (!arst_n)
    (bitWrHit && !byteWrHit && !hwArith && (bitSel == psf_pkg::USER_A_POS)) |=> statusWord_q.userFlagA == $past(bitWrData))
    else $error("bit store to user flag lost");

  // Software store, read miss and bank path checks
  a_user_b_store: assert property (
    @(posedge clk) disable iff (!arst_n)
    (bitWrHit && !byteWrHit && (bitSel == psf_pkg::USER_B_POS)) |=> statusWord_q.userFlagB == $past(bitWrData))
    else $error("bit store to second user flag lost");

  a_byte_store: assert property (
    @(posedge clk) disable iff (!arst_n)
    (byteWrHit && !hwArith) |=> statusVec[psf_pkg::CARRY_POS:psf_pkg::USER_B_POS]
                                == $past(sfrWrData[psf_pkg::CARRY_POS:psf_pkg::USER_B_POS]))
    else $error("byte store did not reach the status word");

  a_read_miss: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sfrRdEn && !byteRdHit) |=> !sfrRdHit_q && (sfrRdData_q == psf_pkg::RD_IDLE))
    else $error("read of another address returned data");

  a_bank_store: assert property (
    @(posedge clk) disable iff (!arst_n)
    byteWrHit |=> bankNow == $past(sfrWrData[psf_pkg::BANK_HI_POS:psf_pkg::BANK_LO_POS]))
    else $error("bank select not taken from byte store");

  a_bank_decode: assert property (
    @(posedge clk) disable iff (!arst_n)
    regAccess |=> (regRamAddr_q >> psf_pkg::REG_IDX_W) == $past(bankNow))
    else $error("register address outside the selected bank");

  a_valid_pulse: assert property (
    @(posedge clk) disable iff (!arst_n)
    !regAccess |=> !regRamValid_q)
    else $error("register address valid without a request");

endmodule // psf_status_word
`default_nettype wire

// ===== psf_status_word_tb_top.sv
// Self-checking testbench of the processor status word block
`timescale 1ns/1ps
`default_nettype none
module psf_status_word_tb_top;
  logic                    clk;
  logic                    arst_n;
  logic [7:0]              sfrAddr, sfrWrData, bitAddr, accValue, sfrRdData_q, regRamAddr_q;
  logic                    sfrWrEn, sfrRdEn, bitWrEn, bitWrData, regAccess, sfrRdHit_q, regRamValid_q;
  logic [2:0]              regIndex;
  psf_pkg::psf_arith_req_t arithReq;
  psf_pkg::psf_status_t    statusWord_q;
  int                      nFail, totalChecks;
  logic [7:0]              accTab [5] = '{8'hff, 8'h80, 8'h7e, 8'h13, 8'h00};

  psf_status_word psf_status_word_inst (
    .clk(clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .sfrRdEn(sfrRdEn), .sfrRdData_q(sfrRdData_q), .sfrRdHit_q(sfrRdHit_q), .bitWrEn(bitWrEn),
    .bitAddr(bitAddr), .bitWrData(bitWrData), .arithReq(arithReq), .accValue(accValue),
    .regAccess(regAccess), .regIndex(regIndex), .regRamAddr_q(regRamAddr_q),
    .regRamValid_q(regRamValid_q), .statusWord_q(statusWord_q)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (nFail == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic at;
    @(posedge clk);
  endtask

  // Strobes drop at the taking edge; outputs are looked at once settled
  task automatic fin;
    @(posedge clk);
    sfrWrEn <= 1'b0;
    sfrRdEn <= 1'b0;
    bitWrEn <= 1'b0;
    regAccess <= 1'b0;
    arithReq.valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    at;
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    fin;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    at;
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    fin;
    chk(sfrRdData_q, exp);
    chk({7'h00, sfrRdHit_q}, {7'h00, hit});
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    at;
    bitAddr <= a;
    bitWrData <= v;
    bitWrEn <= 1'b1;
    fin;
  endtask

  task automatic ra(input logic [2:0] n, input logic [7:0] e);
    at;
    regIndex <= n;
    regAccess <= 1'b1;
    fin;
    chk(regRamAddr_q, e);
    chk({7'h00, regRamValid_q}, 8'h01);
  endtask

  // Expected flags packed as carry, half-carry, exceeds
  task automatic ar(input psf_pkg::psf_op_t op, input logic [7:0] a, input logic [7:0] b,
                    input logic ci, input logic [2:0] e);
    at;
    arithReq <= '{1'b1, op, a, b, ci};
    fin;
    chk({5'h00, statusWord_q.carryFlag, statusWord_q.halfCarryFlag, statusWord_q.arithExceedsFlag}, {5'h00, e});
  endtask

  // Guards against a stuck run
  initial begin
    #200us;
    nFail++;
    finish_test;
  end

  initial begin
    arst_n = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    bitWrEn = 1'b0;
    bitAddr = 8'h00;
    bitWrData = 1'b0;
    accValue = 8'h01;
    arithReq = '0;
    regAccess = 1'b0;
    regIndex = 3'h0;
    repeat (3) @(posedge clk);
    #1;
    chk(statusWord_q, 8'h00);
    chk(sfrRdData_q | regRamAddr_q, 8'h00);
    chk({6'h00, sfrRdHit_q, regRamValid_q}, 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    rd(8'hd0, 8'h01, 1'b1);
    foreach (accTab[i]) begin
      at;
      accValue <= accTab[i];
      fin;
      chk({7'h00, statusWord_q.parityFlag}, {7'h00, ^accTab[i]});
    end
    wr(8'hd0, 8'hfe);
    rd(8'hd0, 8'hfe, 1'b1);
    wr(8'hd0, 8'h01);
    chk(statusWord_q, 8'h00);
    rd(8'hd1, 8'h00, 1'b0);
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b * 8));
      chk(statusWord_q, 8'(b * 8));
      ra(3'(7 - b), 8'(b * 8 + 7 - b));
    end
    // Bank change and register access on one edge: old bank still applies
    at;
    sfrAddr <= 8'hd0;
    sfrWrData <= 8'h10;
    sfrWrEn <= 1'b1;
    regIndex <= 3'h5;
    regAccess <= 1'b1;
    fin;
    chk(regRamAddr_q, 8'h1d);
    ra(3'h5, 8'h15);
    bw(8'hd5, 1'b1);
    bw(8'hd1, 1'b1);
    bw(8'hd0, 1'b1);
    chk(statusWord_q, 8'h32);
    ar(psf_pkg::PSF_OP_ADD, 8'hff, 8'h01, 1'b0, 3'h7);
    ar(psf_pkg::PSF_OP_ADD, 8'h08, 8'h08, 1'b0, 3'h2);
    ar(psf_pkg::PSF_OP_ADD, 8'h10, 8'h10, 1'b0, 3'h0);
    ar(psf_pkg::PSF_OP_ADD, 8'h0f, 8'h00, 1'b1, 3'h2);
    ar(psf_pkg::PSF_OP_SUB, 8'h00, 8'h01, 1'b0, 3'h7);
    ar(psf_pkg::PSF_OP_SUB, 8'h10, 8'h01, 1'b0, 3'h2);
    ar(psf_pkg::PSF_OP_SUB, 8'h05, 8'h05, 1'b1, 3'h7);
    ar(psf_pkg::PSF_OP_MUL, 8'h10, 8'h10, 1'b0, 3'h1);
    ar(psf_pkg::PSF_OP_MUL, 8'h0f, 8'h11, 1'b0, 3'h0);
    ar(psf_pkg::PSF_OP_DIV, 8'h08, 8'h00, 1'b0, 3'h1);
    ar(psf_pkg::PSF_OP_DIV, 8'h08, 8'h02, 1'b0, 3'h0);
    chk(statusWord_q & 8'h3b, 8'h32);
    // Arithmetic beats the byte store, the byte store beats the bit store
    at;
    sfrAddr <= 8'hd0;
    sfrWrData <= 8'h00;
    sfrWrEn <= 1'b1;
    bitAddr <= 8'hd5;
    bitWrData <= 1'b1;
    bitWrEn <= 1'b1;
    arithReq <= '{1'b1, psf_pkg::PSF_OP_ADD, 8'hff, 8'h01, 1'b0};
    fin;
    chk(statusWord_q, 8'hc4);
    // Mid-run reset must clear a non-zero word without waiting for a clock
    at;
    arst_n <= 1'b0;
    #1;
    chk(statusWord_q, 8'h00);
    chk({6'h00, sfrRdHit_q, regRamValid_q}, 8'h00);
    finish_test;
  end
endmodule // psf_status_word_tb_top
`default_nettype wire
